// ===== src/ubc_config.v
`timescale 1ns/1ps
`include "ubc_defines.vh"

module ubc_config (
  input  wire        pclk,               // Bus clock, 25 MHz
  input  wire        presetn,            // Asynchronous reset, active low
  input  wire        psel,               // APB select
  input  wire        penable,            // APB access phase
  input  wire        pwrite,             // APB direction, 1 = write
  input  wire [7:0]  paddr,              // APB byte address
  input  wire [31:0] pwdata,             // APB write data
  output reg  [31:0] prdata,             // APB read data
  output wire        pready,             // APB ready, always 1
  output wire        pslverr,            // APB error on unmapped address
  input  wire        transmitter_enable, // From control register 2
  input  wire        receiver_enable,    // From control register 2
  input  wire        alternate_map_select, // From status register 2
  input  wire        cpu_wait_mode,      // Processor is in wait mode
  input  wire        tx_line,            // Transmitter serial output, NRZ
  input  wire [8:0]  tx_char,            // Character from transmitter
  input  wire [8:0]  rx_char,            // Character from receiver
  input  wire        rx_char_valid,      // Receiver finished a character
  input  wire        rx_idle_seen,       // Receiver counted an idle char
  input  wire        rxd_in,             // Receive pin level
  input  wire        txd_in,             // Transmit pin level read back
  output reg         txd_out,            // Transmit pin drive value
  output reg         txd_oe_n,           // Transmit pin enable, low drives
  output reg         receiver_input,     // Selected receiver serial input
  output reg         baud_tick,          // One sample tick, 16 per bit
  output reg         block_active,       // Block running, not halted
  output reg         frame_nine_bits,    // Nine data bits per frame
  output reg         wake_addr_mark,     // Wake on address mark
  output reg         idle_after_stop,    // Idle count starts after stop
  output reg         parity_enable,      // Parity generation/check on
  output reg         parity_type,        // 1 = odd parity
  output reg  [8:0]  tx_char_par,        // Character with parity placed
  output reg         rx_parity_err,      // Parity mismatch on last char
  output reg         wake_event          // Pulse: receiver wake condition
);

  // Notes for whoever picks this block up next:
  // Bus side
  // - Zero-wait slave: every access phase completes in its first cycle.
  // - Offsets are register indices times four, one word per register.
  // - Only bits 7:0 of the write data are used; upper read bits are zero.
  // - With the alternate map selected the three registers vanish:
  //   writes are dropped, reads return zero, and no error is raised,
  //   because the other map owns these offsets then.
  // - Outside the alternate map, an unused offset raises an error.
  // High byte staging
  // - The whole high byte, infrared enable included, is staged.
  // - It reaches the divisor only with the next low byte write, so the
  //   generator never runs on a half-updated divisor.
  // - Reading the high byte shows the applied copy; software that
  //   writes only the high byte reads the old value back until then.
  // Baud generator
  // - Sleeps after reset until either direction is first enabled;
  //   clearing both enables later does not stop it again.
  // - A zero effective divisor parks the counters at zero.
  // - The wait halt parks the counters too, so a resumed frame starts
  //   from a fresh bit phase rather than mid-bit.
  // - Standard mode: one sample tick every divisor clocks, sixteen
  //   ticks per bit.
  // - Infrared mode: the prescaler runs on the divisor without bit 0
  //   and the phase counter takes thirty-two steps per bit; every
  //   second step gives a sample tick, so the receiver still sees
  //   sixteen ticks per bit.
  // Infrared transmit
  // - A zero bit becomes one pulse at the start of the bit.
  // - The pulse width is counted in thirty-second parts of a bit.
  // - A one bit leaves the line idle.
  // - Limitation: no infrared demodulation; the receive pin passes raw.
  // Pins and routing
  // - The transmit pin idles high and is released whenever the
  //   transmitter is off or the block is halted in wait.
  // - A receiver that is off or halted sees a steady idle line, so
  //   no false start bit can reach it.
  // - Loop select detaches the receive pin; the receiver source bit
  //   then picks the internal path or the transmit pin read back.
  // - Loop use only works with both directions enabled; that is up to
  //   software and is not enforced here.
  // Frame settings
  // - Frame length, wake, idle type and parity bits are passed out one
  //   clock after the register changes.
  // - Parity sits in the top data bit: bit 7 of an eight bit frame,
  //   bit 8 of a nine bit frame.
  // - Even type sets the parity bit for an odd count of ones; the odd
  //   type inverts it.
  // - The parity error flag only moves when a character completes.
  // Wake event
  // - Address mark mode pulses on a finished character whose top bit
  //   is set; idle mode pulses on an idle character from the receiver.

  // Register state
  reg  [7:0]  baud_high_stage;  // Staging copy of the high byte
  reg  [7:0]  baud_high;        // Active high byte
  reg  [7:0]  baud_low;         // Active low byte
  reg  [7:0]  frame_ctl;        // Frame control one
  reg         gen_started;      // Sticky: an enable has been seen
  reg  [12:0] presc;            // Prescaler count
  reg  [4:0]  phase;            // Tick phase inside one bit
  reg         ir_pulse;         // Infrared pulse, active high

  // Decoded fields
  wire        infrared_enable     = baud_high[`UBC_BIT_IR_EN];
  wire [1:0]  narrow_pulse_select = baud_high[`UBC_BIT_PULSE_HI:
                                              `UBC_BIT_PULSE_LO];
  wire [12:0] baud_divisor = {baud_high[`UBC_BIT_DIV_TOP:0], baud_low};
  wire        loop_select     = frame_ctl[`UBC_BIT_LOOP];
  wire        wait_mode_halt  = frame_ctl[`UBC_BIT_WAIT_HALT];
  wire        receiver_source = frame_ctl[`UBC_BIT_RX_SOURCE];

  // APB decode
  wire        acc_wr = psel & penable & pwrite;
  wire        hit_hi = (paddr == `UBC_ADDR_BAUD_HIGH);
  wire        hit_lo = (paddr == `UBC_ADDR_BAUD_LOW);
  wire        hit_fc = (paddr == `UBC_ADDR_FRAME_CTL);
  wire        mapped = hit_hi | hit_lo | hit_fc;
  wire        map_ok = ~alternate_map_select;

  // Effective prescaler period; infrared halves the divisor
  wire [12:0] period = infrared_enable ? {1'b0, baud_divisor[12:1]}
                                       : baud_divisor;
  wire        div_zero = (period == 13'h0000);
  wire        halted   = cpu_wait_mode & wait_mode_halt;
  wire        run      = gen_started & ~div_zero & ~halted;
  wire        presc_hit = run & (presc == period - 13'h0001);
  wire [4:0]  phase_top = infrared_enable ? `UBC_TICKS_IR
                                          : `UBC_TICKS_STD;

  // Zero-wait slave; only bad addresses error out
  assign pready  = 1'b1;
  assign pslverr = psel & penable & map_ok & ~mapped;

  // Register writes; the high byte only lands with the low byte
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_high_stage <= `UBC_RST_BAUD_HIGH;
      baud_high       <= `UBC_RST_BAUD_HIGH;
      baud_low        <= `UBC_RST_BAUD_LOW;
      frame_ctl       <= `UBC_RST_FRAME_CTL;
    end else if (acc_wr && map_ok) begin
      if (hit_hi) begin
        baud_high_stage <= pwdata[7:0];
      end
      if (hit_lo) begin
        baud_low  <= pwdata[7:0];
        baud_high <= baud_high_stage;
      end
      if (hit_fc) begin
        frame_ctl <= pwdata[7:0];
      end
    end
  end

  // Read mux; high byte shows the active copy, not the staged one
  always @* begin
    prdata = 32'h0000_0000;
    if (map_ok) begin
      if (hit_hi) begin
        prdata = {24'h000000, baud_high};
      end else if (hit_lo) begin
        prdata = {24'h000000, baud_low};
      end else if (hit_fc) begin
        prdata = {24'h000000, frame_ctl};
      end
    end
  end

  // Sticky start: the generator sleeps until an enable is first seen
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gen_started <= 1'b0;
    end else if (transmitter_enable | receiver_enable) begin
      gen_started <= 1'b1;
    end
  end

  // Prescaler and bit phase; cleared while stopped so restart is clean
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc <= 13'h0000;
      phase <= 5'h00;
    end else if (!run) begin
      presc <= 13'h0000;
      phase <= 5'h00;
    end else if (presc_hit) begin
      presc <= 13'h0000;
      if (phase >= phase_top) begin
        phase <= 5'h00;
      end else begin
        phase <= phase + 5'h01;
      end
    end else begin
      presc <= presc + 13'h0001;
    end
  end

  // Sample tick: every prescaler hit, or every second in infrared
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_tick <= 1'b0;
    end else if (infrared_enable) begin
      baud_tick <= presc_hit & phase[0];
    end else begin
      baud_tick <= presc_hit;
    end
  end

  // Pulse width in 1/32 bit units from the select field
  reg [4:0] pulse_w;
  always @* begin
    case (narrow_pulse_select)
      `UBC_PULSE_QUARTER: pulse_w = `UBC_W_QUARTER;
      `UBC_PULSE_1_32:    pulse_w = `UBC_W_1_32;
      `UBC_PULSE_1_16:    pulse_w = `UBC_W_1_16;
      `UBC_PULSE_3_16:    pulse_w = `UBC_W_3_16;
      default:            pulse_w = `UBC_W_3_16;
    endcase
  end

  // Infrared modulator: zero bits become one narrow pulse at bit start
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ir_pulse <= 1'b0;
    end else begin
      ir_pulse <= infrared_enable & run & ~tx_line &
                  (phase < pulse_w);
    end
  end

  // Transmit pin: idle high; pulse shows as a low excursion on the pin
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txd_out  <= 1'b1;
      txd_oe_n <= 1'b1;
    end else begin
      txd_oe_n <= ~(transmitter_enable & ~halted);
      if (infrared_enable) begin
        txd_out <= ~ir_pulse;
      end else begin
        txd_out <= tx_line;
      end
    end
  end

  // Receiver source; a disabled receiver sees an idle (high) line
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      receiver_input <= 1'b1;
    end else if (!receiver_enable || halted) begin
      receiver_input <= 1'b1;
    end else if (!loop_select) begin
      receiver_input <= rxd_in;
    end else if (receiver_source) begin
      receiver_input <= txd_in;
    end else begin
      receiver_input <= tx_line;
    end
  end

  // Frame settings passed to transmitter and receiver
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      block_active    <= 1'b0;
      frame_nine_bits <= 1'b0;
      wake_addr_mark  <= 1'b0;
      idle_after_stop <= 1'b0;
      parity_enable   <= 1'b0;
      parity_type     <= 1'b0;
    end else begin
      block_active    <= ~halted;
      frame_nine_bits <= frame_ctl[`UBC_BIT_NINE_BITS];
      wake_addr_mark  <= frame_ctl[`UBC_BIT_WAKE_ADDR];
      idle_after_stop <= frame_ctl[`UBC_BIT_IDLE_TYPE];
      parity_enable   <= frame_ctl[`UBC_BIT_PAR_EN];
      parity_type     <= frame_ctl[`UBC_BIT_PAR_ODD];
    end
  end

  // Parity over the data bits below the MSB; MSB is the parity slot
  wire        nine  = frame_ctl[`UBC_BIT_NINE_BITS];
  wire        odd   = frame_ctl[`UBC_BIT_PAR_ODD];
  wire        pen   = frame_ctl[`UBC_BIT_PAR_EN];
  wire        tx_x7 = ^tx_char[6:0];
  wire        tx_x8 = ^tx_char[7:0];
  wire        rx_x7 = ^rx_char[6:0];
  wire        rx_x8 = ^rx_char[7:0];
  // Even: odd count of ones sets the bit; odd type inverts that
  wire        tx_par = (nine ? tx_x8 : tx_x7) ^ odd;
  wire        rx_par = (nine ? rx_x8 : rx_x7) ^ odd;
  wire        rx_msb = nine ? rx_char[8] : rx_char[7];

  // Place the parity bit, or pass the character untouched
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_char_par <= 9'h000;
    end else if (!pen) begin
      tx_char_par <= tx_char;
    end else if (nine) begin
      tx_char_par <= {tx_par, tx_char[7:0]};
    end else begin
      tx_char_par <= {1'b0, tx_par, tx_char[6:0]};
    end
  end

  // Check received parity on each finished character
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_parity_err <= 1'b0;
    end else if (rx_char_valid) begin
      rx_parity_err <= pen & (rx_msb != rx_par);
    end
  end

  // Wake condition: address mark in the MSB, or an idle character
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_event <= 1'b0;
    end else if (frame_ctl[`UBC_BIT_WAKE_ADDR]) begin
      wake_event <= rx_char_valid & rx_msb;
    end else begin
      wake_event <= rx_idle_seen;
    end
  end

endmodule

// ===== src/ubc_defines.vh
`ifndef UBC_DEFINES_VH
`define UBC_DEFINES_VH

// Register indices as printed; byte address is four times the index
`define UBC_IDX_BAUD_HIGH   8'h00
`define UBC_IDX_BAUD_LOW    8'h01
`define UBC_IDX_FRAME_CTL   8'h02
`define UBC_ADDR_BAUD_HIGH  8'h00
`define UBC_ADDR_BAUD_LOW   8'h04
`define UBC_ADDR_FRAME_CTL  8'h08

// Reset values
`define UBC_RST_BAUD_HIGH   8'h00
`define UBC_RST_BAUD_LOW    8'h04
`define UBC_RST_FRAME_CTL   8'h00

// Baud divisor high byte fields
`define UBC_BIT_IR_EN       7
`define UBC_BIT_PULSE_HI    6
`define UBC_BIT_PULSE_LO    5
`define UBC_BIT_DIV_TOP     4

// Frame control fields
`define UBC_BIT_LOOP        7
`define UBC_BIT_WAIT_HALT   6
`define UBC_BIT_RX_SOURCE   5
`define UBC_BIT_NINE_BITS   4
`define UBC_BIT_WAKE_ADDR   3
`define UBC_BIT_IDLE_TYPE   2
`define UBC_BIT_PAR_EN      1
`define UBC_BIT_PAR_ODD     0

// Narrow pulse codes and widths in 1/32 bit-time units
`define UBC_PULSE_QUARTER   2'b11
`define UBC_PULSE_1_32      2'b10
`define UBC_PULSE_1_16      2'b01
`define UBC_PULSE_3_16      2'b00
`define UBC_W_QUARTER       5'h08
`define UBC_W_1_32          5'h01
`define UBC_W_1_16          5'h02
`define UBC_W_3_16          5'h06

// Sample ticks per bit: 16 standard, 32 half ticks in infrared mode
`define UBC_TICKS_STD       5'h0f
`define UBC_TICKS_IR        5'h1f

`endif

// ===== testbench/tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests = n_tests + 1; if ((a) !== (e)) begin \
  miscompares = miscompares + 1; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module tb;
  reg         pclk, presetn, psel, penable, pwrite;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata;
  reg         transmitter_enable, receiver_enable, alternate_map_select;
  reg         cpu_wait_mode, tx_line, rx_char_valid, rx_idle_seen, send_lo;
  reg  [8:0]  tx_char, rx_char;
  wire [31:0] prdata;
  wire [8:0]  tx_char_par;
  wire        pready, pslverr, rxd, txd_pin, txd_out, txd_oe_n, perr;
  wire        rx_in, baud_tick, f9, fw, fi, fpe, fpt, act, wk;
  integer     miscompares, n_tests, i, k, c;
  reg  [31:0] rd;      // Last read data
  reg         err;     // Last error response
  reg         par;     // Expected parity bit
  reg  [16:0] rows [0:10]; // {write, addr, data or expected}
  ubc_config i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .transmitter_enable,
    .receiver_enable, .alternate_map_select, .cpu_wait_mode, .tx_line,
    .tx_char, .rx_char, .rx_char_valid, .rx_idle_seen, .rxd_in(rxd),
    .txd_in(txd_pin), .txd_out, .txd_oe_n, .receiver_input(rx_in),
    .baud_tick, .block_active(act), .frame_nine_bits(f9),
    .wake_addr_mark(fw), .idle_after_stop(fi), .parity_enable(fpe),
    .parity_type(fpt), .tx_char_par, .rx_parity_err(perr),
    .wake_event(wk));
  ubc_peer i_peer (.txd_out, .txd_oe_n, .send_lo, .txd_pin, .rxd);
  // 25 MHz bus clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // Verdict and end of run
  task close_out;
    begin
      $display("tests %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  // One transfer; request held until pready is seen high
  task apb(input w, input [7:0] a, input [7:0] d);
    integer t;
    begin
      t = 0;
      @(posedge pclk); // Let the last release settle first
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
        @(posedge pclk);
        t = t + 1;
      end while (pready !== 1'b1 && t < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (t >= 20) begin
        miscompares = miscompares + 1;
        close_out;
      end
    end
  endtask
  // Sum ticks, or low pin cycles, over n edges
  task cnt(input integer n, input sel);
    begin
      c = 0;
      repeat (n) begin
        @(posedge pclk);
        c = c + (sel ? !txd_out : baud_tick);
      end
    end
  endtask
  // Clocks between two ticks; a stuck generator gives 300
  task period;
    begin
      c = 0;
      while (baud_tick !== 1'b1 && c < 300) begin
        @(posedge pclk);
        c = c + 1;
      end
      c = 0;
      do begin
        @(posedge pclk);
        c = c + 1;
      end while (baud_tick !== 1'b1 && c < 300);
    end
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = 0;
    {transmitter_enable, receiver_enable, alternate_map_select} = 3'b000;
    {cpu_wait_mode, tx_line, rx_char_valid, rx_idle_seen} = 4'b0100;
    {send_lo, tx_char, rx_char} = 19'h0;
    {miscompares, n_tests} = 0;
    presetn = 1'b0;
    // Staged high byte reads stale until the low byte lands
    rows[0] = {1'b0, 8'h00, 8'h00};
    rows[1] = {1'b0, 8'h04, 8'h04};
    rows[2] = {1'b0, 8'h08, 8'h00};
    rows[3] = {1'b1, 8'h00, 8'he0};
    rows[4] = {1'b0, 8'h00, 8'h00};
    rows[5] = {1'b1, 8'h04, 8'h08};
    rows[6] = {1'b0, 8'h00, 8'he0};
    rows[7] = {1'b0, 8'h04, 8'h08};
    rows[8] = {1'b1, 8'h08, 8'h1f};
    rows[9] = {1'b0, 8'h08, 8'h1f};
    rows[10] = {1'b0, 8'h0c, 8'h00};
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (i = 0; i < 11; i = i + 1) begin
      apb(rows[i][16], rows[i][15:8], rows[i][7:0]);
      if (!rows[i][16])
        `CHK({err, rd}, {rows[i][15:8] == 8'h0c, 24'h0,
                         rows[i][7:0]})
    end
    `CHK({f9, fw, fi, fpe, fpt}, 5'h1f)
    cnt(60, 1'b0);
    `CHK(c, 0)
    transmitter_enable <= 1'b1;
    period;
    `CHK(c, 8)
    apb(1'b1, 8'h00, 8'h00);
    apb(1'b1, 8'h04, 8'h06);
    period;
    `CHK(c, 6)
    apb(1'b1, 8'h00, 8'h80);
    apb(1'b1, 8'h04, 8'h01);
    cnt(60, 1'b0);
    `CHK(c, 0)
    // Zero bits at D=8, halved to 4: one bit time is 128 clocks
    tx_line <= 1'b0;
    for (k = 0; k < 4; k = k + 1) begin
      apb(1'b1, 8'h00, {1'b1, k[1:0], 5'h0});
      apb(1'b1, 8'h04, 8'h08);
      cnt(300, 1'b0);
      cnt(128, 1'b1);
      `CHK(c, 4 * (k == 3 ? 8 : k == 2 ? 1 : k == 1 ? 2 : 6))
    end
    apb(1'b1, 8'h08, 8'h40);
    cpu_wait_mode <= 1'b1;
    cnt(60, 1'b0);
    `CHK({c[7:0], txd_oe_n, act}, 10'h002)
    cpu_wait_mode <= 1'b0;
    apb(1'b1, 8'h00, 8'h00);
    apb(1'b1, 8'h04, 8'h08); // Applies the staged byte: infrared off
    receiver_enable <= 1'b1; // Loop use needs both directions
    // Normal, internal loop, single wire; then inverted levels
    for (k = 0; k < 6; k = k + 1) begin
      tx_line <= k > 2;
      send_lo <= k > 2;
      apb(1'b1, 8'h08, (k % 3 == 0) ? 8'h00 : (k % 3 == 1) ? 8'h80 : 8'ha0);
      repeat (4) @(posedge pclk);
      `CHK(rx_in, (k % 3 == 0) ? ~send_lo : tx_line)
    end
    tx_char <= 9'h0a5;
    // Parity: k[1] nine bits, k[0] odd; odd rows get a bad bit
    for (k = 0; k < 4; k = k + 1) begin
      apb(1'b1, 8'h08, {3'b0, k[1], 2'b0, 1'b1, k[0]});
      repeat (3) @(posedge pclk);
      par = (k[1] ? ^tx_char[7:0] : ^tx_char[6:0]) ^ k[0];
      `CHK(k[1] ? tx_char_par[8] : tx_char_par[7], par)
      rx_char <= k[1] ? {par ^ k[0], 8'ha5} : {1'b0, par ^ k[0], 7'h25};
      rx_char_valid <= 1'b1;
      @(posedge pclk);
      rx_char_valid <= 1'b0;
      repeat (2) @(posedge pclk);
      `CHK(perr, k[0])
    end
    alternate_map_select <= 1'b1;
    apb(1'b1, 8'h08, 8'hff);
    apb(1'b0, 8'h08, 8'h00);
    `CHK({err, rd}, 33'h0)
    alternate_map_select <= 1'b0;
    apb(1'b0, 8'h08, 8'h00);
    `CHK(rd, 32'h13)
    // Wake: address mark in bit 7 first, then an idle character
    for (k = 0; k < 2; k = k + 1) begin
      apb(1'b1, 8'h08, k[0] ? 8'h00 : 8'h08);
      rx_char <= 9'h080;
      rx_char_valid <= ~k[0];
      rx_idle_seen <= k[0];
      @(posedge pclk);
      {rx_char_valid, rx_idle_seen} <= 2'b00;
      @(posedge pclk);
      `CHK(wk, 1'b1)
    end
    close_out;
  end
endmodule

// ===== testbench/ubc_asserts.sv
`timescale 1ns/1ps
module ubc_asserts (
  input wire        pclk,                 // Bus clock
  input wire        presetn,              // Reset, active low
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pslverr,
  input wire        transmitter_enable,
  input wire        receiver_enable,
  input wire        alternate_map_select,
  input wire        cpu_wait_mode,
  input wire        rx_char_valid,
  input wire        txd_oe_n,
  input wire        receiver_input,
  input wire        baud_tick,
  input wire        frame_nine_bits,
  input wire        parity_type,
  input wire        rx_parity_err
);
  wire acc; // Access phase of any transfer
  wire wr_ctl; // Accepted frame control write
  reg  started; // Set once either direction has been enabled
  assign acc = psel & penable;
  assign wr_ctl = acc & pwrite & ~alternate_map_select & (paddr == 8'h08);
  // Sticky start flag, cleared only by reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      started <= 1'b0;
    else if (transmitter_enable | receiver_enable)
      started <= 1'b1;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_alt_rd;
    acc && !pwrite && alternate_map_select |-> prdata == 32'h0 && !pslverr;
  endproperty
  a_alt_rd: assert property (p_alt_rd) else $error("hidden map read");
  property p_unmap;
    acc && !alternate_map_select && !(paddr inside {8'h00, 8'h04, 8'h08})
      |-> pslverr && prdata == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped access");
  property p_oe_off;
    !transmitter_enable |=> txd_oe_n;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("pin driven");
  property p_oe_on;
    transmitter_enable && !cpu_wait_mode |=> !txd_oe_n;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("pin released");
  property p_rx_off;
    !receiver_enable |=> receiver_input;
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("rx input live");
  property p_start;
    !started |-> !baud_tick;
  endproperty
  a_start: assert property (p_start) else $error("early tick");
  property p_len;
    wr_ctl |-> ##2 frame_nine_bits == $past(pwdata[4], 2);
  endproperty
  a_len: assert property (p_len) else $error("frame length");
  property p_pty;
    wr_ctl |-> ##2 parity_type == $past(pwdata[0], 2);
  endproperty
  a_pty: assert property (p_pty) else $error("parity type");
  property p_perr;
    !$stable(rx_parity_err) |-> $past(rx_char_valid);
  endproperty
  a_perr: assert property (p_perr) else $error("parity flag moved");
  c_tick: cover property (baud_tick);
  c_err: cover property (pslverr);
  c_perr: cover property (rx_parity_err);
endmodule
bind ubc_config ubc_asserts i_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pslverr, .transmitter_enable,
  .receiver_enable, .alternate_map_select, .cpu_wait_mode, .rx_char_valid,
  .txd_oe_n, .receiver_input, .baud_tick, .frame_nine_bits, .parity_type,
  .rx_parity_err);

// ===== testbench/ubc_peer.sv
`timescale 1ns/1ps
// Far node: pull-up on the transmit wire, drives the receive wire
module ubc_peer (
  input  wire txd_out,  // Device drive value
  input  wire txd_oe_n, // Device enable, low drives
  input  wire send_lo,  // Hold a space on the receive wire
  output wire txd_pin,  // Resolved transmit wire
  output wire rxd       // Receive wire
);
  // A released wire floats to the pull-up, never the last value
  assign txd_pin = txd_oe_n ? 1'b1 : txd_out;
  // Idle mark unless a space is asked for
  assign rxd = ~send_lo;
endmodule
